// ### design/swr_pkg.sv
// Shared constants, commands, states and CRC helpers of the single-wire
// identity/memory link. Used by both ends and the bench.
package swr_pkg;

   // Memory geometry
   localparam int DMEM_BYTES = 128;
   localparam int PAGE_BYTES = 32;
   localparam int STAT_BYTES = 8;
   localparam int STAT_OTP_LAST = 6;
   localparam logic [15:0] STAT_RAM_ADDR = 16'h0007;
   localparam int ID_BITS = 64;

   // Values after reset, and the RAM commit byte
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] FACTORY = 8'h00;
   localparam logic [7:0] STAT_RAM_RST = 8'h00;
   localparam logic [7:0] COMMIT_RAM = 8'hff;

   // Identity-level commands
   localparam logic [7:0] CMD_READ_ID = 8'h33;
   localparam logic [7:0] CMD_MATCH_ID = 8'h55;
   localparam logic [7:0] CMD_SKIP_ID = 8'hcc;
   localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;
   localparam logic [7:0] CMD_COND_ID = 8'hec;

   // Memory and control commands
   localparam logic [7:0] CMD_WR_MEM = 8'h0f;
   localparam logic [7:0] CMD_WR_STAT = 8'h55;
   localparam logic [7:0] CMD_RD_MEM = 8'hf0;
   localparam logic [7:0] CMD_RD_STAT = 8'haa;
   localparam logic [7:0] CMD_RD_EXT = 8'ha5;
   localparam logic [7:0] CMD_CHAN = 8'hf5;

   // Master operations
   localparam logic [1:0] OP_ID = 2'h0;
   localparam logic [1:0] OP_WR = 2'h1;
   localparam logic [1:0] OP_RD = 2'h2;

   // CRC polynomials, bit-reversed for LSB-first shifting
   localparam logic [7:0] CRC8_POLY = 8'h8c;
   localparam logic [15:0] CRC16_POLY = 16'ha001;

   typedef enum logic [10:0] {
      S_DEAD = 11'h001, S_ROM = 11'h002, S_MATCH = 11'h004, S_IDTX = 11'h008,
      S_FUNC = 11'h010, S_AL = 11'h020, S_AH = 11'h040, S_DATA = 11'h080,
      S_CRC = 11'h100, S_COMMIT = 11'h200, S_RD = 11'h400
   } swr_dev_e;

   typedef enum logic [6:0] {
      M_IDLE = 7'h01, M_RST = 7'h02, M_TX = 7'h04, M_RX = 7'h08,
      M_WAIT = 7'h10, M_EVAL = 7'h20, M_DONE = 7'h40
   } swr_mst_e;

   // One bit into the x^8+x^5+x^4+1 register
   function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      return {1'b0, c[7:1]} ^ (fb ? CRC8_POLY : 8'h00);
   endfunction

   function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[0] ^ b;
      return {1'b0, c[15:1]} ^ (fb ? CRC16_POLY : 16'h0000);
   endfunction

   // Check byte over family then serial, from zero
   function automatic logic [7:0] crc8_id(input logic [7:0] fam, input logic [47:0] ser);
      logic [7:0] c;
      logic [55:0] d;
      c = 8'h00;
      d = {ser, fam};
      for (int i = 0; i < 56; i++)
      begin
         c = crc8_bit(c, d[i]);
      end
      return c;
   endfunction

endpackage

// ### design/swr_if.sv
// Single-wire link between the bus master and the device, one slot per
// clock. Both ends share i_clk; the bench joins them.
`timescale 1ns/1ps
`default_nettype none
interface swr_if;
   logic bus_rst;
   logic slot;
   logic wr;
   logic wbit;
   logic prog;
   logic rbit;

   modport dev (input bus_rst, input slot, input wr, input wbit, input prog, output rbit);
   modport mst (output bus_rst, output slot, output wr, output wbit, output prog, input rbit);
endinterface
`default_nettype wire

// ### design/swr_device.sv
// Device end: identity code, command gate, OTP data and status memories
// behind a scratchpad. Assumes the master drives the link from the same clock.
`timescale 1ns/1ps
`default_nettype none
module swr_device #(
   parameter logic [7:0] FAMILY = 8'h5a,         // Arbitrary value
   parameter logic [47:0] SERIAL = 48'h0123_4567_89ab  // Arbitrary value
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Link
   swr_if.dev bus,
   // User side
   output logic [7:0] o_ctrl,
   output logic o_sel
);

   localparam logic [63:0] ID = {swr_pkg::crc8_id(FAMILY, SERIAL), SERIAL, FAMILY};

   swr_pkg::swr_dev_e state;
   logic [7:0] rx_sh;
   logic [63:0] tx_sh;
   logic [6:0] cnt;
   logic [7:0] cmd;
   logic [15:0] addr;
   logic [7:0] scratch;
   logic loaded;
   logic [15:0] crc;
   logic [7:0] mem [swr_pkg::DMEM_BYTES];
   logic [7:0] stat [swr_pkg::STAT_BYTES];

   logic wslot;
   logic rslot;
   logic [7:0] byte_in;
   logic byte_end;
   logic [15:0] crc_nx;
   logic [15:0] raddr;
   logic [7:0] rd_byte;
   logic is_wr;
   logic do_prog;
   logic do_ram;

   assign wslot = bus.slot & bus.wr;
   assign rslot = bus.slot & ~bus.wr;
   assign byte_in = {bus.wbit, rx_sh[7:1]};
   assign byte_end = wslot && (cnt[2:0] == 3'h7);
   assign crc_nx = swr_pkg::crc16_bit(crc, bus.wbit);
   assign is_wr = (cmd == swr_pkg::CMD_WR_MEM) || (cmd == swr_pkg::CMD_WR_STAT);
   assign do_prog = (state == swr_pkg::S_COMMIT) && loaded && bus.prog;
   assign do_ram = (state == swr_pkg::S_COMMIT) && loaded && byte_end
                   && (byte_in == swr_pkg::COMMIT_RAM);
   assign bus.rbit = tx_sh[0];
   assign o_ctrl = stat[7];

   // Byte to read: first at the loaded address, then the following one
   always_comb
   begin
      raddr = (state == swr_pkg::S_AH) ? {byte_in, addr[7:0]} : addr + 16'h0001;
      if (cmd == swr_pkg::CMD_RD_STAT)
      begin
         rd_byte = (raddr[15:3] == 13'h0000) ? stat[raddr[2:0]] : swr_pkg::ERASED;
      end
      else
      begin
         rd_byte = (raddr[15:7] == 9'h000) ? mem[raddr[6:0]] : swr_pkg::ERASED;
      end
   end

   // Receive shifter
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rx_sh <= 8'h00;
      else if (wslot)
         rx_sh <= byte_in;
   end

   // CRC16 over command, address and data
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         crc <= 16'h0000;
      else if (bus.bus_rst)
         crc <= 16'h0000;
      else if (wslot && (state == swr_pkg::S_FUNC || state == swr_pkg::S_AL
                         || state == swr_pkg::S_AH || state == swr_pkg::S_DATA))
         crc <= crc_nx;
   end

   // Command sequencer
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state <= swr_pkg::S_DEAD;
         cnt <= 7'h00;
         cmd <= 8'h00;
         addr <= 16'h0000;
         scratch <= swr_pkg::ERASED;
         loaded <= 1'b0;
         tx_sh <= {64{1'b1}};
         o_sel <= 1'b0;
      end
      else if (bus.bus_rst)
      begin
         state <= swr_pkg::S_ROM;
         cnt <= 7'h00;
         loaded <= 1'b0;
         tx_sh <= {64{1'b1}};
         o_sel <= 1'b0;
      end
      else
      begin
         case (state)
            swr_pkg::S_ROM:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (byte_end)
               begin
                  cnt <= 7'h00;
                  case (byte_in)
                     swr_pkg::CMD_READ_ID:
                     begin
                        tx_sh <= ID;
                        state <= swr_pkg::S_IDTX;
                     end
                     swr_pkg::CMD_MATCH_ID: state <= swr_pkg::S_MATCH;
                     swr_pkg::CMD_SKIP_ID:
                     begin
                        state <= swr_pkg::S_FUNC;
                        o_sel <= 1'b1;
                     end
                     default: state <= swr_pkg::S_DEAD;
                  endcase
               end
            end
            swr_pkg::S_MATCH:
            begin
               if (wslot)
               begin
                  cnt <= cnt + 7'h01;
                  if (bus.wbit != ID[cnt[5:0]])
                     state <= swr_pkg::S_DEAD;
                  else if (cnt == 7'h3f)
                  begin
                     cnt <= 7'h00;
                     state <= swr_pkg::S_FUNC;
                     o_sel <= 1'b1;
                  end
               end
            end
            swr_pkg::S_IDTX:
            begin
               if (rslot)
               begin
                  tx_sh <= {1'b1, tx_sh[63:1]};
                  cnt <= cnt + 7'h01;
                  if (cnt == 7'h3f)
                  begin
                     cnt <= 7'h00;
                     state <= swr_pkg::S_FUNC;
                     o_sel <= 1'b1;
                  end
               end
            end
            swr_pkg::S_FUNC:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (byte_end)
               begin
                  cnt <= 7'h00;
                  cmd <= byte_in;
                  if (byte_in == swr_pkg::CMD_WR_MEM || byte_in == swr_pkg::CMD_WR_STAT
                      || byte_in == swr_pkg::CMD_RD_MEM || byte_in == swr_pkg::CMD_RD_STAT)
                     state <= swr_pkg::S_AL;
                  else
                     state <= swr_pkg::S_DEAD;
               end
            end
            swr_pkg::S_AL:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (byte_end)
               begin
                  cnt <= 7'h00;
                  addr[7:0] <= byte_in;
                  state <= swr_pkg::S_AH;
               end
            end
            swr_pkg::S_AH:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (byte_end)
               begin
                  cnt <= 7'h00;
                  addr[15:8] <= byte_in;
                  if (is_wr)
                     state <= swr_pkg::S_DATA;
                  else
                  begin
                     tx_sh <= {{56{1'b1}}, rd_byte};
                     state <= swr_pkg::S_RD;
                  end
               end
            end
            swr_pkg::S_DATA:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (byte_end)
               begin
                  cnt <= 7'h00;
                  scratch <= byte_in;
                  loaded <= 1'b1;
                  tx_sh <= {{48{1'b1}}, crc_nx};
                  state <= swr_pkg::S_CRC;
               end
            end
            swr_pkg::S_CRC:
            begin
               if (rslot)
               begin
                  tx_sh <= {1'b1, tx_sh[63:1]};
                  cnt <= cnt + 7'h01;
                  if (cnt == 7'h0f)
                  begin
                     cnt <= 7'h00;
                     state <= swr_pkg::S_COMMIT;
                  end
               end
            end
            swr_pkg::S_COMMIT:
            begin
               if (wslot)
                  cnt <= cnt + 7'h01;
               if (bus.prog || byte_end)
               begin
                  loaded <= 1'b0;
                  state <= swr_pkg::S_DEAD;
               end
            end
            swr_pkg::S_RD:
            begin
               if (rslot)
               begin
                  cnt <= cnt + 7'h01;
                  tx_sh <= {1'b1, tx_sh[63:1]};
                  if (cnt == 7'h07)
                  begin
                     cnt <= 7'h00;
                     addr <= raddr;
                     tx_sh <= {{56{1'b1}}, rd_byte};
                  end
               end
            end
            default: state <= swr_pkg::S_DEAD;
         endcase
      end
   end

   // Data memory, one byte per entry
   for (genvar i = 0; i < swr_pkg::DMEM_BYTES; i++)
   begin : g_mem
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
         if (!i_nrst)
            mem[i] <= swr_pkg::ERASED;
         else if (do_prog && cmd == swr_pkg::CMD_WR_MEM && addr == 16'(i)
                  && stat[0][i / swr_pkg::PAGE_BYTES])
            mem[i] <= mem[i] & scratch;
      end
   end

   // Status memory: OTP bytes then one RAM byte
   for (genvar i = 0; i < swr_pkg::STAT_BYTES; i++)
   begin : g_stat
      localparam logic [7:0] RV = (i < 5) ? swr_pkg::ERASED :
                                  (i <= swr_pkg::STAT_OTP_LAST) ? swr_pkg::FACTORY :
                                  swr_pkg::STAT_RAM_RST;
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
         if (!i_nrst)
            stat[i] <= RV;
         else if (i <= swr_pkg::STAT_OTP_LAST)
         begin
            if (do_prog && cmd == swr_pkg::CMD_WR_STAT && addr == 16'(i))
               stat[i] <= stat[i] & scratch;
         end
         else if (do_ram && cmd == swr_pkg::CMD_WR_STAT
                  && addr == swr_pkg::STAT_RAM_ADDR)
            stat[i] <= scratch;
      end
   end

endmodule
`default_nettype wire

// ### design/swr_master.sv
// Bus master end: runs identity read, verified write and read operations
// over the link. Assumes the device shares i_clk.
`timescale 1ns/1ps
`default_nettype none
module swr_master (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Operation request
   input wire logic i_go,
   input wire logic [1:0] i_op,
   input wire logic i_stat,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_data,
   // Operation result
   output logic o_busy,
   output logic o_done,
   output logic o_ok,
   output logic [7:0] o_rdata,
   output logic [63:0] o_id,
   // Link
   swr_if.mst bus
);

   swr_pkg::swr_mst_e state;
   logic [39:0] tx_q;
   logic [6:0] ntx;
   logic [6:0] nrx;
   logic [6:0] cnt;
   logic [63:0] rx_q;
   logic [7:0] crc8;
   logic [15:0] crc16;
   logic [1:0] op;
   logic is_ram;
   logic commit;

   // Sample answered read slots
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_q <= 64'h0;
         crc8 <= 8'h00;
      end
      else if (state == swr_pkg::M_RST)
         crc8 <= 8'h00;
      else if (bus.slot && !bus.wr)
      begin
         rx_q <= {bus.rbit, rx_q[63:1]};
         crc8 <= swr_pkg::crc8_bit(crc8, bus.rbit);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state <= swr_pkg::M_IDLE;
         tx_q <= 40'h0;
         ntx <= 7'h00;
         nrx <= 7'h00;
         cnt <= 7'h00;
         crc16 <= 16'h0000;
         op <= swr_pkg::OP_ID;
         is_ram <= 1'b0;
         commit <= 1'b0;
         bus.bus_rst <= 1'b0;
         bus.slot <= 1'b0;
         bus.wr <= 1'b0;
         bus.wbit <= 1'b1;
         bus.prog <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_ok <= 1'b0;
         o_rdata <= 8'h00;
         o_id <= 64'h0;
      end
      else
      begin
         bus.bus_rst <= 1'b0;
         bus.slot <= 1'b0;
         bus.prog <= 1'b0;
         o_done <= 1'b0;
         case (state)
            swr_pkg::M_IDLE:
            begin
               if (i_go)
               begin
                  op <= i_op;
                  is_ram <= i_stat && (i_addr == swr_pkg::STAT_RAM_ADDR);
                  commit <= 1'b0;
                  crc16 <= 16'h0000;
                  o_busy <= 1'b1;
                  state <= swr_pkg::M_RST;
                  // Identity command always leads
                  case (i_op)
                     swr_pkg::OP_WR:
                     begin
                        tx_q <= {i_data, i_addr[15:8], i_addr[7:0],
                                 i_stat ? swr_pkg::CMD_WR_STAT : swr_pkg::CMD_WR_MEM,
                                 swr_pkg::CMD_SKIP_ID};
                        ntx <= 7'd40;
                        nrx <= 7'd16;
                     end
                     swr_pkg::OP_RD:
                     begin
                        tx_q <= {8'hff, i_addr[15:8], i_addr[7:0],
                                 i_stat ? swr_pkg::CMD_RD_STAT : swr_pkg::CMD_RD_MEM,
                                 swr_pkg::CMD_SKIP_ID};
                        ntx <= 7'd32;
                        nrx <= 7'd8;
                     end
                     default:
                     begin
                        tx_q <= {32'hffff_ffff, swr_pkg::CMD_READ_ID};
                        ntx <= 7'd8;
                        nrx <= 7'd64;
                     end
                  endcase
               end
            end
            swr_pkg::M_RST:
            begin
               bus.bus_rst <= 1'b1;
               cnt <= 7'h00;
               state <= swr_pkg::M_TX;
            end
            swr_pkg::M_TX:
            begin
               bus.slot <= 1'b1;
               bus.wr <= 1'b1;
               bus.wbit <= tx_q[0];
               tx_q <= {1'b1, tx_q[39:1]};
               if (cnt >= 7'd8 && !commit)
                  crc16 <= swr_pkg::crc16_bit(crc16, tx_q[0]);
               cnt <= cnt + 7'h01;
               if (cnt == ntx - 7'h01)
               begin
                  cnt <= 7'h00;
                  state <= commit ? swr_pkg::M_WAIT : swr_pkg::M_RX;
               end
            end
            swr_pkg::M_RX:
            begin
               bus.slot <= 1'b1;
               bus.wr <= 1'b0;
               cnt <= cnt + 7'h01;
               if (cnt == nrx - 7'h01)
               begin
                  cnt <= 7'h00;
                  state <= swr_pkg::M_WAIT;
               end
            end
            swr_pkg::M_WAIT: state <= swr_pkg::M_EVAL;
            swr_pkg::M_EVAL:
            begin
               state <= swr_pkg::M_DONE;
               if (commit)
                  o_ok <= 1'b1;
               else if (op == swr_pkg::OP_WR)
               begin
                  o_ok <= 1'b0;
                  if (rx_q[63:48] == crc16)
                  begin
                     commit <= 1'b1;
                     if (is_ram)
                     begin
                        tx_q <= {32'hffff_ffff, swr_pkg::COMMIT_RAM};
                        ntx <= 7'd8;
                        state <= swr_pkg::M_TX;
                     end
                     else
                     begin
                        bus.prog <= 1'b1;
                        o_ok <= 1'b1;
                     end
                  end
               end
               else if (op == swr_pkg::OP_RD)
               begin
                  o_rdata <= rx_q[63:56];
                  o_ok <= 1'b1;
               end
               else
               begin
                  o_id <= rx_q;
                  o_ok <= (crc8 == 8'h00);
               end
            end
            swr_pkg::M_DONE:
            begin
               o_done <= 1'b1;
               o_busy <= 1'b0;
               state <= swr_pkg::M_IDLE;
            end
            default: state <= swr_pkg::M_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### verification/swr_chk.sv
// Link checker: timing relations between the master and device ends.
// Assumes one clock domain and the swr_if signals given as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module swr_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Link
   input wire logic bus_rst,
   input wire logic slot,
   input wire logic wr,
   input wire logic wbit,
   input wire logic prog,
   input wire logic rbit
);
   logic [7:0] cnt;

   // Slots since the last bus reset
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cnt <= 8'h00;
      else if (bus_rst)
         cnt <= 8'h00;
      else if (slot)
         cnt <= cnt + 8'h01;
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_start;
      bus_rst ##1 !bus_rst;
   endsequence
   sequence s_first_write;
      ##[0:3] (slot && wr && cnt == 8'h00);
   endsequence

   AST_RST_PULSE: assert property (bus_rst |=> !bus_rst)
      else $error("bus reset longer than one cycle");
   AST_FIRST_WRITE: assert property (s_start |-> s_first_write)
      else $error("no command byte after bus reset");
   AST_ID_BYTE_WRITE: assert property (slot && cnt < 8'h08 |-> wr)
      else $error("identity byte slot is not a write");
   AST_CRC_READ: assert property (slot && cnt >= 8'h28 && cnt < 8'h38 |-> !wr)
      else $error("check word slot is not a read");
   AST_PROG_LOADED: assert property (prog |-> cnt == 8'h38)
      else $error("programming pulse without loaded scratchpad");
   AST_PROG_PULSE: assert property (prog |=> (!prog && !slot) [*2])
      else $error("programming pulse not alone");
   AST_RST_ALONE: assert property (bus_rst |-> !slot && !prog)
      else $error("bus reset overlaps a slot");
   AST_RBIT_HOLD: assert property (!$stable(rbit) |-> $past(slot || bus_rst || prog))
      else $error("read bit moved outside a slot");
endmodule
`default_nettype wire

// ### verification/test_single_wire_rom_memory_front.sv
// Bench: master and device joined by swr_if, results checked from a queue.
// Assumes one 50 MHz clock and the constants of swr_pkg.
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_rom_memory_front;
   localparam logic [7:0] FAM = 8'h3c; // Arbitrary value
   localparam logic [47:0] SER = 48'h9e37_79b9_7f4a; // Arbitrary value
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_go = 1'b0;
   logic [1:0] i_op = 2'h0;
   logic i_stat = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_data = 8'h00;
   logic o_busy, o_done, o_ok, o_sel;
   logic [7:0] o_rdata, o_ctrl;
   logic [63:0] o_id;
   logic [7:0] mem [0:127];
   logic [7:0] st [0:7];
   logic [72:0] exp_q [$];
   logic [1:0] kind_q [$];
   logic [72:0] e;
   int num_errors = 0;
   int num_checks = 0;
   int seed = 15487;
   int cycles = 0;

   swr_if link ();
   swr_device #(.FAMILY(FAM), .SERIAL(SER)) swr_device_i (.i_clk(i_clk), .i_nrst(i_nrst),
      .bus(link.dev), .o_ctrl(o_ctrl), .o_sel(o_sel));
   swr_master swr_master_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(i_go), .i_op(i_op),
      .i_stat(i_stat), .i_addr(i_addr), .i_data(i_data), .o_busy(o_busy), .o_done(o_done),
      .o_ok(o_ok), .o_rdata(o_rdata), .o_id(o_id), .bus(link.mst));
   swr_chk swr_chk_i (.i_clk(i_clk), .i_nrst(i_nrst), .bus_rst(link.bus_rst),
      .slot(link.slot), .wr(link.wr), .wbit(link.wbit), .prog(link.prog), .rbit(link.rbit));

   always #10 i_clk = ~i_clk;

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      num_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   // Check byte, family then serial, from zero
   function automatic logic [7:0] id_crc(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
      begin
         c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
      end
      return c;
   endfunction

   task automatic op(input logic [1:0] o, input logic s, input logic [7:0] a,
      input logic [7:0] d);
      logic [7:0] v;
      v = 8'hff;
      if (o == swr_pkg::OP_WR && s && a == 8'h07)
         st[7] = d;
      else if (o == swr_pkg::OP_WR && s)
         st[a[2:0]] = st[a[2:0]] & d;
      else if (o == swr_pkg::OP_WR && st[0][a[6:5]])
         mem[a[6:0]] = mem[a[6:0]] & d;
      if (s)
         v = st[a[2:0]];
      else if (!a[7])
         v = mem[a[6:0]];
      exp_q.push_back({1'b1, v, id_crc({SER, FAM}), SER, FAM});
      kind_q.push_back(o);
      @(posedge i_clk);
      i_go <= 1'b1;
      i_op <= o;
      i_stat <= s;
      i_addr <= {8'h00, a};
      i_data <= d;
      @(posedge i_clk);
      i_go <= 1'b0;
      @(negedge i_clk);
      chk({63'h0, o_busy}, 64'h1);
      do @(negedge i_clk); while (o_done !== 1'b1);
   endtask

   // Result monitor
   always @(negedge i_clk)
   begin
      if (o_done === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         chk({63'h0, o_ok}, {63'h0, e[72]});
         chk({63'h0, o_busy}, 64'h0);
         if (kind_q[0] == swr_pkg::OP_RD)
            chk({56'h0, o_rdata}, {56'h0, e[71:64]});
         if (kind_q[0] == swr_pkg::OP_ID)
            chk(o_id, e[63:0]);
         void'(kind_q.pop_front());
      end
   end

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      logic [7:0] a;
      logic [7:0] d;
      foreach (mem[i])
         mem[i] = 8'hff;
      st = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      op(swr_pkg::OP_ID, 1'b0, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++)
         op(swr_pkg::OP_RD, 1'b1, i[7:0], 8'h00);
      repeat (6)
      begin
         a = 8'($random(seed)) & 8'h7f;
         d = 8'($random(seed));
         op(swr_pkg::OP_WR, 1'b0, a, d);
         op(swr_pkg::OP_WR, 1'b0, a, 8'($random(seed)));
         op(swr_pkg::OP_RD, 1'b0, a, 8'h00);
         chk({63'h0, o_sel}, 64'h1);
      end
      repeat (2)
      begin
         d = 8'($random(seed));
         op(swr_pkg::OP_WR, 1'b1, 8'h07, d);
         chk({56'h0, o_ctrl}, {56'h0, d});
         op(swr_pkg::OP_RD, 1'b1, 8'h07, 8'h00);
      end
      op(swr_pkg::OP_WR, 1'b1, 8'h00, 8'hf7);
      op(swr_pkg::OP_WR, 1'b0, 8'h60, 8'h00);
      op(swr_pkg::OP_RD, 1'b0, 8'h60, 8'h00);
      op(swr_pkg::OP_RD, 1'b0, 8'h9f, 8'h00);
      // Reset in mid-run: memories and selection return to reset values
      @(posedge i_clk);
      i_nrst <= 1'b0;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      chk({56'h0, o_ctrl}, {56'h0, swr_pkg::STAT_RAM_RST});
      chk({63'h0, o_sel}, 64'h0);
      foreach (mem[i])
         mem[i] = 8'hff;
      st = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
      @(posedge i_clk);
      i_nrst <= 1'b1;
      op(swr_pkg::OP_RD, 1'b1, 8'h07, 8'h00);
      op(swr_pkg::OP_WR, 1'b0, 8'h60, 8'h5a);
      op(swr_pkg::OP_RD, 1'b0, 8'h60, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
